//--- flash_page_lock_guard.sv
// access guard deciding debug and firmware flash reads, writes and erases by requester and lock state
`timescale 1ns/1ps
module flash_page_lock_guard #(
  parameter int PAGE_BITS = flash_guard_pkg::PAGE_BITS_DEFAULT,
  parameter int ADDR_BITS = flash_guard_pkg::ADDR_BITS_DEFAULT,
  parameter logic [12:0] LOCK_ADDR     = 13'h1DFF,
  parameter logic [12:0] RESERVED_BASE = 13'h1E00
)(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          clk_en,
  // access request
  input  wire logic                          req_valid,
  input  wire flash_guard_pkg::flash_req_type req,
  // verdict, one cycle after the request
  output logic                               grant_valid,
  output flash_guard_pkg::verdict_type       verdict,
  output logic [7:0]                         lock_rdata,
  // flash side effects
  output logic                               flash_write_en,
  output logic                               flash_page_erase_en,
  output logic                               flash_mass_erase_en,
  output logic [12:0]                        flash_addr,
  output logic [7:0]                         flash_wdata,
  // device reset request
  output logic                               fault_reset_req,
  input  wire logic                          device_reset_done,
  // register port
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [7:0]                         reg_rdata,
  output logic                               irq
);

  // page that holds the lock byte
  localparam logic [PAGE_BITS-1:0] LOCK_PAGE = LOCK_ADDR[ADDR_BITS-1 -: PAGE_BITS];

  // ==========================================================
  // state
  // stored is the value held in flash, active the copy that governs the checks
  logic [7:0]                           lock_stored_reg;
  logic [7:0]                           lock_stored_next;
  logic [7:0]                           lock_active_reg;
  logic [7:0]                           lock_active_next;
  logic                                 lock_written_reg;
  logic                                 lock_written_next;
  logic                                 fault_flag_reg;
  logic                                 fault_flag_next;
  logic                                 fault_req_reg;
  logic                                 fault_req_next;
  logic [flash_guard_pkg::EVT_BITS-1:0] status_reg;
  logic [flash_guard_pkg::EVT_BITS-1:0] status_next;
  logic [flash_guard_pkg::EVT_BITS-1:0] mask_reg;
  logic [flash_guard_pkg::EVT_BITS-1:0] mask_next;
  logic                                 gv_reg;
  logic                                 gv_next;
  flash_guard_pkg::verdict_type         vd_reg;
  flash_guard_pkg::verdict_type         vd_next;
  logic [7:0]                           lrd_reg;
  logic [7:0]                           lrd_next;
  logic                                 fw_reg;
  logic                                 fw_next;
  logic                                 fpe_reg;
  logic                                 fpe_next;
  logic                                 fme_reg;
  logic                                 fme_next;
  logic [12:0]                          fa_reg;
  logic [12:0]                          fa_next;
  logic [7:0]                           fd_reg;
  logic [7:0]                           fd_next;
  logic [7:0]                           rd_reg;
  logic [7:0]                           rd_next;

  // ==========================================================
  // page classification
  // page index of a flash address: the top address bits pick the page
  function automatic logic [PAGE_BITS-1:0] page_of(input logic [12:0] a);
    page_of = a[ADDR_BITS-1 -: PAGE_BITS];
  endfunction

  // a clear lock bit locks its page; pages beyond the lock byte's width
  // can never be locked one by one, only the lock page follows any lock
  function automatic logic page_locked(input logic [12:0] a, input logic [7:0] lb);
    logic [PAGE_BITS-1:0] pg;
    logic                 any;
    pg  = page_of(a);
    any = (lb != flash_guard_pkg::LOCK_ERASED);
    if (pg == LOCK_PAGE)
    begin
      page_locked = any;
    end
    else if (int'(pg) < flash_guard_pkg::DATA_BITS)
    begin
      page_locked = !lb[pg[2:0]];
    end
    else
    begin
      page_locked = 1'b0;
    end
  endfunction

  logic any_locked;
  logic tgt_locked;
  logic src_locked;
  logic tgt_lock_page;
  logic tgt_lock_byte;
  logic tgt_reserved;
  logic is_dbg;
  logic is_fw;
  logic ok;

  always_comb
  begin
    any_locked    = (lock_active_reg != flash_guard_pkg::LOCK_ERASED);
    tgt_locked    = page_locked(req.addr, lock_active_reg);
    src_locked    = page_locked(req.code_addr, lock_active_reg);
    tgt_lock_page = (page_of(req.addr) == LOCK_PAGE);
    tgt_lock_byte = (req.addr == LOCK_ADDR);
    tgt_reserved  = (req.addr >= RESERVED_BASE);
    is_dbg        = (req.who == flash_guard_pkg::REQ_DEBUG);
    is_fw         = (req.who == flash_guard_pkg::REQ_FW);
    ok            = 1'b0;
    // the checks read the active lock copy, so a firmware lock write cannot
    // shut out the code that made it before the next device reset
    if (req.op == flash_guard_pkg::OP_DEV_ERASE)
    begin
      ok = is_dbg;
    end
    else if (tgt_reserved)
    begin
      ok = 1'b0;
    end
    else if (tgt_lock_page && req.op == flash_guard_pkg::OP_ERASE)
    begin
      ok = is_dbg && !any_locked;
    end
    else if (tgt_lock_byte && req.op == flash_guard_pkg::OP_WRITE)
    begin
      // any change once written is refused; bit changes count as lock edits
      ok = !lock_written_reg && (!any_locked || (is_fw && src_locked));
    end
    else if (tgt_lock_page)
    begin
      ok = !any_locked || (is_fw && src_locked);
    end
    else if (tgt_locked)
    begin
      ok = is_fw && src_locked;
    end
    else
    begin
      ok = 1'b1;
    end
  end

  // ==========================================================
  // decision and flash control
  always_comb
  begin
    lock_stored_next  = lock_stored_reg;
    lock_active_next  = lock_active_reg;
    lock_written_next = lock_written_reg;
    fault_flag_next   = fault_flag_reg;
    fault_req_next    = fault_req_reg;
    gv_next  = 1'b0;
    vd_next  = '0;
    lrd_next = lrd_reg;
    fw_next  = 1'b0;
    fpe_next = 1'b0;
    fme_next = 1'b0;
    fa_next  = fa_reg;
    fd_next  = fd_reg;
    if (device_reset_done)
    begin
      lock_active_next = lock_stored_reg;
      fault_req_next   = 1'b0;
    end
    // while a fault reset is pending the core is about to restart: ignore requests, no grant or verdict
    if (req_valid && (is_dbg || is_fw) && !fault_req_reg)
    begin
      gv_next       = 1'b1;
      vd_next.allow = ok;
      vd_next.drop  = !ok && is_dbg;
      vd_next.fault = !ok && is_fw;
      fa_next       = req.addr;
      fd_next       = req.wdata;
      if (!ok && is_fw)
      begin
        fault_req_next  = 1'b1;
        fault_flag_next = 1'b1;
      end
      if (ok)
      begin
        unique case (req.op)
          flash_guard_pkg::OP_READ:
            if (tgt_lock_byte)
              lrd_next = lock_stored_reg;
          flash_guard_pkg::OP_WRITE:
          begin
            fw_next = 1'b1;
            if (tgt_lock_byte)
            begin
              lock_stored_next  = req.wdata;
              lock_written_next = 1'b1;
              if (is_dbg)
                lock_active_next = req.wdata;
            end
          end
          flash_guard_pkg::OP_ERASE:
          begin
            fpe_next = 1'b1;
            if (tgt_lock_page)
            begin
              lock_stored_next  = flash_guard_pkg::LOCK_ERASED;
              lock_active_next  = flash_guard_pkg::LOCK_ERASED;
              lock_written_next = 1'b0;
            end
          end
          flash_guard_pkg::OP_DEV_ERASE:
          begin
            fme_next          = 1'b1;
            lock_stored_next  = flash_guard_pkg::LOCK_ERASED;
            lock_active_next  = flash_guard_pkg::LOCK_ERASED;
            lock_written_next = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // register port and interrupts
  logic [flash_guard_pkg::EVT_BITS-1:0] evt;
  always_comb
  begin
    evt = '0;
    evt[flash_guard_pkg::EVT_DROP_BIT]  = gv_next && vd_next.drop;
    evt[flash_guard_pkg::EVT_FAULT_BIT] = gv_next && vd_next.fault;
    status_next = status_reg;
    mask_next   = mask_reg;
    rd_next     = flash_guard_pkg::ZERO_BYTE;
    if (reg_rd)
    begin
      unique case (reg_addr)
        flash_guard_pkg::REG_RESET_CAUSE:
          rd_next[flash_guard_pkg::FAULT_FLAG_BIT] = fault_flag_reg;
        flash_guard_pkg::REG_IRQ_STATUS:
        begin
          rd_next[flash_guard_pkg::EVT_BITS-1:0] = status_reg;
          status_next = '0;
        end
        flash_guard_pkg::REG_IRQ_MASK:
          rd_next[flash_guard_pkg::EVT_BITS-1:0] = mask_reg;
        flash_guard_pkg::REG_LOCK_ACTIVE:
          rd_next = lock_active_reg;
        flash_guard_pkg::REG_LOCK_STORED:
          rd_next = lock_stored_reg;
        default:
          rd_next = flash_guard_pkg::ZERO_BYTE;
      endcase
    end
    if (reg_wr && reg_addr == flash_guard_pkg::REG_IRQ_MASK)
      mask_next = reg_wdata[flash_guard_pkg::EVT_BITS-1:0];
    // set wins over the read clear
    status_next = status_next | evt;
  end

  // cause flag is cleared by writing zero to bit 0 of the cause register
  logic fault_flag_final;
  always_comb
  begin
    fault_flag_final = fault_flag_next;
    if (reg_wr && reg_addr == flash_guard_pkg::REG_RESET_CAUSE &&
        !reg_wdata[flash_guard_pkg::FAULT_FLAG_BIT] && !vd_next.fault)
      fault_flag_final = 1'b0;
  end

  // lock byte copies and fault reset state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_stored_reg  <= flash_guard_pkg::LOCK_ERASED;
      lock_active_reg  <= flash_guard_pkg::LOCK_ERASED;
      lock_written_reg <= 1'b0;
      fault_flag_reg   <= 1'b0;
      fault_req_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      lock_stored_reg  <= lock_stored_next;
      lock_active_reg  <= lock_active_next;
      lock_written_reg <= lock_written_next;
      fault_flag_reg   <= fault_flag_final;
      fault_req_reg    <= fault_req_next;
    end
  end

  // verdict and flash strobes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gv_reg  <= 1'b0;
      vd_reg  <= '0;
      lrd_reg <= flash_guard_pkg::ZERO_BYTE;
      fw_reg  <= 1'b0;
      fpe_reg <= 1'b0;
      fme_reg <= 1'b0;
      fa_reg  <= '0;
      fd_reg  <= flash_guard_pkg::ZERO_BYTE;
    end
    else if (clk_en)
    begin
      gv_reg  <= gv_next;
      vd_reg  <= vd_next;
      lrd_reg <= lrd_next;
      fw_reg  <= fw_next;
      fpe_reg <= fpe_next;
      fme_reg <= fme_next;
      fa_reg  <= fa_next;
      fd_reg  <= fd_next;
    end
  end

  // interrupt status, mask and register read data
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= '0;
      mask_reg   <= '0;
      rd_reg     <= flash_guard_pkg::ZERO_BYTE;
    end
    else if (clk_en)
    begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rd_reg     <= rd_next;
    end
  end

  // ==========================================================
  // outputs
  assign grant_valid         = gv_reg;
  assign verdict             = vd_reg;
  assign lock_rdata          = lrd_reg;
  assign flash_write_en      = fw_reg;
  assign flash_page_erase_en = fpe_reg;
  assign flash_mass_erase_en = fme_reg;
  assign flash_addr          = fa_reg;
  assign flash_wdata         = fd_reg;
  assign fault_reset_req     = fault_req_reg;
  assign reg_rdata           = rd_reg;
  assign irq                 = |(status_reg & mask_reg);

endmodule

//--- flash_guard_pkg.sv
// shared constants and carrier types for the flash page lock guard
package flash_guard_pkg;

  // ==========================================================
  // geometry
  localparam int PAGE_BITS_DEFAULT  = 4;
  localparam int ADDR_BITS_DEFAULT  = 13;
  localparam int DATA_BITS          = 8;

  // ==========================================================
  // requester and operation codes
  typedef enum logic [1:0]
  {
    REQ_DEBUG   = 2'b00,
    REQ_FW      = 2'b01,
    REQ_NONE    = 2'b10
  } requester_type;

  typedef enum logic [1:0]
  {
    OP_READ     = 2'b00,
    OP_WRITE    = 2'b01,
    OP_ERASE    = 2'b10,
    OP_DEV_ERASE = 2'b11
  } flash_op_type;

  // ==========================================================
  // access request carrier
  typedef struct packed
  {
    requester_type who;
    flash_op_type  op;
    logic [12:0]   addr;
    logic [12:0]   code_addr;
    logic [7:0]    wdata;
  } flash_req_type;

  // verdict carrier
  typedef struct packed
  {
    logic allow;
    logic drop;
    logic fault;
  } verdict_type;

  // ==========================================================
  // register map and fields
  localparam logic [3:0] REG_RESET_CAUSE = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS  = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK    = 4'h2;
  localparam logic [3:0] REG_LOCK_ACTIVE = 4'h3;
  localparam logic [3:0] REG_LOCK_STORED = 4'h4;
  localparam int FAULT_FLAG_BIT = 0;
  localparam int EVT_DROP_BIT   = 0;
  localparam int EVT_FAULT_BIT  = 1;
  localparam int EVT_BITS       = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] LOCK_ERASED   = 8'hFF;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

endpackage

//--- flash_guard_chk.sv
// concurrent checks on the flash page lock guard ports
`timescale 1ns/1ps
module flash_guard_chk #(
  parameter logic [12:0] RESERVED_BASE = 13'h1E00
)(
  // watched ports
  input wire logic                           clk,
  input wire logic                           arst_n,
  input wire logic                           clk_en,
  input wire logic                           req_valid,
  input wire flash_guard_pkg::flash_req_type req,
  input wire logic                           grant_valid,
  input wire flash_guard_pkg::verdict_type   verdict,
  input wire logic                           flash_mass_erase_en,
  input wire logic                           fault_reset_req,
  input wire logic                           device_reset_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_verdict_one_hot: assert property (
    grant_valid |-> $onehot(verdict)) else $error("verdict not one-hot");
  a_debug_never_faults: assert property (
    grant_valid && $past(req.who) == flash_guard_pkg::REQ_DEBUG |-> !verdict.fault
    && !fault_reset_req) else $error("debug refusal caused a fault");
  a_fault_starts_reset: assert property (
    grant_valid && verdict.fault |-> fault_reset_req) else $error("fault without reset");
  a_reserved_refused: assert property (
    grant_valid && $past(req.addr) >= RESERVED_BASE |-> !verdict.allow)
    else $error("reserved area access allowed");
  a_open_pages_free: assert property (
    grant_valid && $past(req.addr[12:9]) inside {[4'h8:4'hD]}
    && $past(req.op) != flash_guard_pkg::OP_DEV_ERASE |-> verdict.allow)
    else $error("unlockable page refused");
  a_mass_by_debug: assert property (
    flash_mass_erase_en |-> grant_valid && verdict.allow
    && $past(req.who) == flash_guard_pkg::REQ_DEBUG) else $error("bad device erase");
  a_fw_dev_erase: assert property (
    grant_valid && $past(req.who) == flash_guard_pkg::REQ_FW
    && $past(req.op) == flash_guard_pkg::OP_DEV_ERASE |-> verdict.fault)
    else $error("firmware device erase not faulted");
  a_reset_req_holds: assert property (
    fault_reset_req && !device_reset_done |=> fault_reset_req) else $error("reset dropped");
  a_reset_req_ends: assert property (
    fault_reset_req && device_reset_done |=> !fault_reset_req) else $error("reset stuck");
  a_grant_has_cause: assert property (
    grant_valid |-> $past(req_valid && clk_en && !fault_reset_req))
    else $error("grant without request");
endmodule

bind flash_page_lock_guard flash_guard_chk #(.RESERVED_BASE(RESERVED_BASE)) chk_u (
  .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
  .grant_valid(grant_valid), .verdict(verdict), .flash_mass_erase_en(flash_mass_erase_en),
  .fault_reset_req(fault_reset_req), .device_reset_done(device_reset_done));

//--- flash_reset_partner.sv
// device reset sequencer model answering fault reset requests
`timescale 1ns/1ps
module flash_reset_partner (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // request, pace and extra reset
  input  wire logic fault_reset_req,
  input  wire logic slow,
  input  wire logic kick,
  output logic      device_reset_done
);
  logic [3:0] wait_reg;
  // slow mode stretches the reset so requests can arrive, and be ignored, while it is pending
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      wait_reg          <= 4'h0;
      device_reset_done <= 1'b0;
    end
    else
    begin
      device_reset_done <= kick || (fault_reset_req && wait_reg == (slow ? 4'h6 : 4'h1));
      wait_reg          <= (fault_reset_req && !device_reset_done) ? wait_reg + 4'h1 : 4'h0;
    end
endmodule

//--- test_flash_page_lock_guard.sv
// self-checking bench for the flash page lock guard
`timescale 1ns/1ps
module test_flash_page_lock_guard;
  localparam logic [12:0] LK = 13'h1DFF;
  localparam flash_guard_pkg::requester_type DBG = flash_guard_pkg::REQ_DEBUG;
  localparam flash_guard_pkg::requester_type FW = flash_guard_pkg::REQ_FW;
  localparam flash_guard_pkg::flash_op_type RD = flash_guard_pkg::OP_READ;
  localparam flash_guard_pkg::flash_op_type WR = flash_guard_pkg::OP_WRITE;
  localparam flash_guard_pkg::flash_op_type ER = flash_guard_pkg::OP_ERASE;
  localparam flash_guard_pkg::flash_op_type DE = flash_guard_pkg::OP_DEV_ERASE;
  localparam logic [2:0] ALW = 3'h4;
  localparam logic [2:0] DRP = 3'h2;
  localparam logic [2:0] FLT = 3'h1;
  logic clk, arst_n, clk_en, req_valid, reg_wr, reg_rd, slow, kick, irq;
  logic grant_valid, write_en, erase_en, mass_en, fault_reset_req, reset_done;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, lock_rdata, flash_wdata, reg_rdata;
  logic [12:0] flash_addr;
  flash_guard_pkg::flash_req_type req;
  flash_guard_pkg::verdict_type   verdict;
  int num_errors = 0;
  int compares = 0;

  flash_page_lock_guard dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .grant_valid(grant_valid), .verdict(verdict),
    .lock_rdata(lock_rdata), .flash_write_en(write_en), .flash_page_erase_en(erase_en),
    .flash_mass_erase_en(mass_en), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .fault_reset_req(fault_reset_req), .device_reset_done(reset_done), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  flash_reset_partner peer_u (.clk(clk), .arst_n(arst_n), .fault_reset_req(fault_reset_req),
    .slow(slow), .kick(kick), .device_reset_done(reset_done));

  // ==========================================
  // access tasks
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic acc(input flash_guard_pkg::requester_type w,
    input flash_guard_pkg::flash_op_type o, input logic [12:0] a, input logic [12:0] c,
    input logic [7:0] d, input logic [2:0] e);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{who: w, op: o, addr: a, code_addr: c, wdata: d};
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk(grant_valid === 1'b1 && verdict === e, "verdict");
  endtask
  // a request that the guard must ignore: no grant may follow it
  task automatic ign(input flash_guard_pkg::requester_type w, input logic [12:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{who: w, op: RD, addr: a, code_addr: 13'h0000, wdata: 8'h00};
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk(grant_valid === 1'b0, "ignored request granted");
  endtask
  // a firmware fault must raise the reset request and see it answered
  task automatic flt(input flash_guard_pkg::flash_op_type o, input logic [12:0] a,
    input logic [12:0] c, input logic [7:0] d);
    int n;
    acc(FW, o, a, c, d, FLT);
    chk(fault_reset_req === 1'b1, "no reset request");
    if (slow)
      ign(DBG, 13'h0600);
    n = 0;
    while (fault_reset_req !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(fault_reset_req === 1'b0, "reset request stuck");
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata === e, "register read");
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // clock, watchdog, tests
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #50000;
    num_errors++;
    give_verdict;
  end
  initial
  begin
    {arst_n, req_valid, reg_wr, reg_rd, slow, kick} = 6'h00;
    req = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    clk_en = 1'b1;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    wr(flash_guard_pkg::REG_IRQ_MASK, 8'h02);
    rd(flash_guard_pkg::REG_IRQ_MASK, 8'h02);
    ign(flash_guard_pkg::REQ_NONE, 13'h0600);
    @(posedge clk);
    clk_en <= 1'b0;
    ign(DBG, 13'h0600);
    @(posedge clk);
    clk_en <= 1'b1;
    acc(DBG, RD, 13'h0600, 13'h0000, 8'h00, ALW);
    acc(DBG, WR, 13'h1000, 13'h0000, 8'h5A, ALW);
    chk(write_en === 1'b1 && flash_wdata === 8'h5A, "write strobe");
    chk(flash_addr === 13'h1000, "flash address");
    acc(FW, RD, LK, 13'h0000, 8'h00, ALW);
    chk(lock_rdata === 8'hFF, "lock value");
    acc(DBG, WR, 13'h1C00, 13'h0000, 8'h00, ALW);
    acc(DBG, ER, 13'h1C00, 13'h0000, 8'h00, ALW);
    chk(erase_en === 1'b1, "page erase strobe");
    flt(ER, 13'h1C00, 13'h0100, 8'h00);
    chk(irq === 1'b1, "irq not raised");
    rd(flash_guard_pkg::REG_IRQ_STATUS, 8'h02);
    chk(irq === 1'b0, "irq not cleared");
    rd(flash_guard_pkg::REG_RESET_CAUSE, 8'h01);
    wr(flash_guard_pkg::REG_RESET_CAUSE, 8'h00);
    rd(flash_guard_pkg::REG_RESET_CAUSE, 8'h00);
    acc(DBG, RD, 13'h1E00, 13'h0000, 8'h00, DRP);
    chk(fault_reset_req === 1'b0 && irq === 1'b0, "debug drop reset or masked irq");
    slow <= 1'b1;
    flt(WR, 13'h1F00, 13'h0000, 8'h00);
    slow <= 1'b0;
    acc(DBG, WR, LK, 13'h0000, 8'hFE, ALW);
    rd(flash_guard_pkg::REG_LOCK_ACTIVE, 8'hFE);
    acc(DBG, WR, LK, 13'h0000, 8'hFC, DRP);
    acc(DBG, WR, LK, 13'h0000, 8'hFF, DRP);
    rd(flash_guard_pkg::REG_LOCK_STORED, 8'hFE);
    acc(DBG, RD, 13'h0010, 13'h0000, 8'h00, DRP);
    acc(DBG, RD, LK, 13'h0000, 8'h00, DRP);
    acc(DBG, WR, 13'h1C00, 13'h0000, 8'h00, DRP);
    acc(FW, RD, 13'h0010, 13'h0020, 8'h00, ALW);
    acc(FW, RD, LK, 13'h0020, 8'h00, ALW);
    chk(lock_rdata === 8'hFE, "lock value locked");
    acc(FW, WR, 13'h1C00, 13'h0020, 8'h00, ALW);
    flt(RD, 13'h0010, 13'h0220, 8'h00);
    flt(ER, 13'h1C00, 13'h0020, 8'h00);
    flt(WR, LK, 13'h0020, 8'hFC);
    flt(DE, 13'h0000, 13'h0020, 8'h00);
    acc(DBG, ER, 13'h1C00, 13'h0000, 8'h00, DRP);
    acc(DBG, DE, 13'h0000, 13'h0000, 8'h00, ALW);
    chk(mass_en === 1'b1, "device erase strobe");
    rd(flash_guard_pkg::REG_LOCK_ACTIVE, 8'hFF);
    acc(DBG, RD, 13'h0010, 13'h0000, 8'h00, ALW);
    acc(FW, WR, LK, 13'h0000, 8'hFD, ALW);
    rd(flash_guard_pkg::REG_LOCK_ACTIVE, 8'hFF);
    rd(flash_guard_pkg::REG_LOCK_STORED, 8'hFD);
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    rd(flash_guard_pkg::REG_LOCK_ACTIVE, 8'hFD);
    acc(DBG, RD, 13'h0210, 13'h0000, 8'h00, DRP);
    acc(DBG, RD, 13'h1C00, 13'h0000, 8'h00, DRP);
    rd(flash_guard_pkg::REG_IRQ_STATUS, 8'h03);
    rd(flash_guard_pkg::REG_RESET_CAUSE, 8'h01);
    rd(4'h7, 8'h00);
    give_verdict;
  end
endmodule
